// >>> rtl/fqb_defs.svh
`ifndef FQB_DEFS_SVH
`define FQB_DEFS_SVH
// query table offsets, index form (byte address = 4 * index)
`define FQB_IDX_PAGE_SIZE 8'h4C
`define FQB_IDX_BURST_CNT 8'h4D
`define FQB_IDX_BURST_1 8'h4E
`define FQB_IDX_BURST_2 8'h4F
`define FQB_IDX_BURST_3 8'h50
`define FQB_IDX_BURST_4 8'h51
`define FQB_IDX_PART_CNT 8'h52
// entry contents
`define FQB_VAL_PAGE_SIZE 8'h03
`define FQB_VAL_BURST_CNT 8'h04
`define FQB_VAL_BURST_1 8'h01
`define FQB_VAL_BURST_2 8'h02
`define FQB_VAL_BURST_3 8'h03
`define FQB_VAL_BURST_4 8'h07
`define FQB_VAL_PART_CNT_DEF 8'h01
// burst field layout
`define FQB_BURST_N_MSB 2
`define FQB_BURST_CONT 3'h7
// address width, word-index bits
`define FQB_AW 10
`define FQB_IW 8
`endif

// >>> rtl/fqb_pkg.sv
`default_nettype none
package fqb_pkg;
   typedef struct packed {
      logic read;
      logic write;
      logic [9:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } fqb_req_type;
   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
      logic readdatavalid;
   } fqb_rsp_type;
endpackage
`default_nettype wire

// >>> rtl/fqb_query_table.sv
`include "fqb_defs.svh"
`default_nettype none
module fqb_query_table #(
   parameter logic [7:0] PART_COUNT = `FQB_VAL_PART_CNT_DEF
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // avalon-mm slave
   input wire fqb_pkg::fqb_req_type avmReq,
   output fqb_pkg::fqb_rsp_type avmRsp
);
   import fqb_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_LOOK = 3'b010,
      ST_DONE = 3'b100
   } fqb_state_type;

   fqb_state_type state_ff;
   fqb_state_type nxt_state;
   logic [31:0] readData_ff;
   logic waitReq_ff;
   logic rdValid_ff;
   logic isRead_ff;
   logic [`FQB_IW-1:0] romIndex_ff;
   logic [7:0] romData;
   logic romHit;

   // request decode
   wire logic reqAny = avmReq.read | avmReq.write;
   wire logic [`FQB_IW-1:0] reqIndex = avmReq.address[`FQB_AW-1:2];
   wire logic wordAligned = (avmReq.address[1:0] == 2'h0);
   wire logic [`FQB_IW-1:0] reqSel = wordAligned ? reqIndex : 8'h00;
   // table index follows the bus on the taking edge, so entry data is ready one cycle later
   wire logic takeReq = (state_ff == ST_IDLE) && reqAny;
   wire logic [`FQB_IW-1:0] romIndex = takeReq ? reqSel : romIndex_ff;

   // constant table, writes never reach it
   // no write path
   fqb_table_rom #(
      .PART_COUNT(PART_COUNT)
   ) uRom (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .index(romIndex),
      .data(romData),
      .hit(romHit)
   );

   // next state: idle, one lookup cycle, release
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (reqAny) begin
               nxt_state = ST_LOOK;
            end
         end
         ST_LOOK: nxt_state = ST_DONE;
         ST_DONE: nxt_state = ST_IDLE;
         default: nxt_state = ST_IDLE;
      endcase
   end

   wire logic [31:0] nxt_readData = (isRead_ff && romHit) ? {24'h000000, romData} : 32'h00000000;
   wire logic nxt_waitReq = !(state_ff == ST_LOOK);

   // state and request capture
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= ST_IDLE;
         romIndex_ff <= 8'h00;
         isRead_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         if (takeReq) begin
            romIndex_ff <= reqSel;
            isRead_ff <= avmReq.read;
         end
      end
   end

   // response registers
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         readData_ff <= 32'h00000000;
         waitReq_ff <= 1'b1;
         rdValid_ff <= 1'b0;
      end else begin
         waitReq_ff <= nxt_waitReq;
         rdValid_ff <= (state_ff == ST_LOOK) && isRead_ff;
         if (state_ff == ST_LOOK) begin
            readData_ff <= nxt_readData;
         end
      end
   end

   assign avmRsp = '{readdata: readData_ff, waitrequest: waitReq_ff, readdatavalid: rdValid_ff};

   // assertion helpers
   wire logic ack = !waitReq_ff && reqAny;
   // misaligned addresses count as index zero, outside the table
   wire logic [`FQB_IW-1:0] ackIdx = reqSel;

   property p_page_size;
      @(posedge ref_clk) disable iff (!reset_n)
      (ack && avmReq.read && ackIdx == `FQB_IDX_PAGE_SIZE) |-> (avmRsp.readdata == 32'h00000003);
   endproperty
   a_page_size: assert property (p_page_size) else $error("page size entry wrong");

   property p_page_nonzero;
      @(posedge ref_clk) disable iff (!reset_n)
      (ack && avmReq.read && ackIdx == `FQB_IDX_PAGE_SIZE) |-> (avmRsp.readdata[7:0] != 8'h00);
   endproperty
   a_page_nonzero: assert property (p_page_nonzero) else $error("page buffer advertised absent");

   property p_burst_count;
      @(posedge ref_clk) disable iff (!reset_n)
      (ack && avmReq.read && ackIdx == `FQB_IDX_BURST_CNT) |-> (avmRsp.readdata == 32'h00000004);
   endproperty
   a_burst_count: assert property (p_burst_count) else $error("burst count entry wrong");

   property p_burst_nonzero;
      @(posedge ref_clk) disable iff (!reset_n)
      (ack && avmReq.read && ackIdx == `FQB_IDX_BURST_CNT) |-> (avmRsp.readdata[7:0] != 8'h00);
   endproperty
   a_burst_nonzero: assert property (p_burst_nonzero) else $error("burst capability absent");

   // burst codes use low three bits
   property p_burst_field;
      @(posedge ref_clk) disable iff (!reset_n)
      (ack && avmReq.read && ackIdx >= `FQB_IDX_BURST_1 && ackIdx <= `FQB_IDX_BURST_4)
         |-> (avmRsp.readdata[31:3] == 29'h0);
   endproperty
   a_burst_field: assert property (p_burst_field) else $error("burst reserved bits set");

   property p_burst_cont;
      @(posedge ref_clk) disable iff (!reset_n)
      (ack && avmReq.read && ackIdx == `FQB_IDX_BURST_4) |-> (avmRsp.readdata[2:0] == `FQB_BURST_CONT);
   endproperty
   a_burst_cont: assert property (p_burst_cont) else $error("continuous burst code missing");

   property p_burst_opts;
      @(posedge ref_clk) disable iff (!reset_n)
      (ack && avmReq.read && ackIdx == `FQB_IDX_BURST_2) |-> (avmRsp.readdata == 32'h00000002);
   endproperty
   a_burst_opts: assert property (p_burst_opts) else $error("burst option two wrong");

   property p_part_count;
      @(posedge ref_clk) disable iff (!reset_n)
      (ack && avmReq.read && ackIdx == `FQB_IDX_PART_CNT) |-> (avmRsp.readdata == {24'h0, PART_COUNT});
   endproperty
   a_part_count: assert property (p_part_count) else $error("region count wrong");

   property p_unmapped;
      @(posedge ref_clk) disable iff (!reset_n)
      (ack && avmReq.read && (ackIdx < `FQB_IDX_PAGE_SIZE || ackIdx > `FQB_IDX_PART_CNT))
         |-> (avmRsp.readdata == 32'h0);
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

   // answer within three cycles of request
   property p_latency;
      @(posedge ref_clk) disable iff (!reset_n)
      ($rose(reqAny) && state_ff == ST_IDLE) |-> ##[1:3] !avmRsp.waitrequest;
   endproperty
   a_latency: assert property (p_latency) else $error("no answer in time");

   property p_burst_opt_one;
      @(posedge ref_clk) disable iff (!reset_n)
      (ack && avmReq.read && ackIdx == `FQB_IDX_BURST_1) |-> (avmRsp.readdata == 32'h00000001);
   endproperty
   a_burst_opt_one: assert property (p_burst_opt_one) else $error("burst option one wrong");

   property p_burst_opt_three;
      @(posedge ref_clk) disable iff (!reset_n)
      (ack && avmReq.read && ackIdx == `FQB_IDX_BURST_3) |-> (avmRsp.readdata == 32'h00000003);
   endproperty
   a_burst_opt_three: assert property (p_burst_opt_three) else $error("burst option three wrong");

   property p_burst_opt_four;
      @(posedge ref_clk) disable iff (!reset_n)
      (ack && avmReq.read && ackIdx == `FQB_IDX_BURST_4) |-> (avmRsp.readdata == 32'h00000007);
   endproperty
   a_burst_opt_four: assert property (p_burst_opt_four) else $error("burst option four wrong");

   property p_upper_zero;
      @(posedge ref_clk) disable iff (!reset_n)
      (ack && avmReq.read) |-> (avmRsp.readdata[31:8] == 24'h000000);
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper read bytes not zero");

   property p_nonzero_in_range;
      @(posedge ref_clk) disable iff (!reset_n)
      (ack && avmReq.read && avmRsp.readdata != 32'h00000000)
         |-> (ackIdx >= `FQB_IDX_PAGE_SIZE && ackIdx <= `FQB_IDX_PART_CNT);
   endproperty
   a_nonzero_in_range: assert property (p_nonzero_in_range) else $error("data outside table");

   property p_misaligned_zero;
      @(posedge ref_clk) disable iff (!reset_n)
      (ack && avmReq.read && !wordAligned) |-> (avmRsp.readdata == 32'h00000000);
   endproperty
   a_misaligned_zero: assert property (p_misaligned_zero) else $error("misaligned read not zero");

   property p_write_no_valid;
      @(posedge ref_clk) disable iff (!reset_n)
      (ack && avmReq.write) |-> (!avmRsp.readdatavalid && avmRsp.readdata == 32'h00000000);
   endproperty
   a_write_no_valid: assert property (p_write_no_valid) else $error("write answer carries data");

   // read answer flagged valid
   property p_read_valid;
      @(posedge ref_clk) disable iff (!reset_n)
      (ack && avmReq.read) |-> avmRsp.readdatavalid;
   endproperty
   a_read_valid: assert property (p_read_valid) else $error("read answer not flagged");

   // answer lasts one cycle
   property p_wait_pulse;
      @(posedge ref_clk) disable iff (!reset_n)
      !avmRsp.waitrequest |=> avmRsp.waitrequest;
   endproperty
   a_wait_pulse: assert property (p_wait_pulse) else $error("answer longer than one cycle");

   // valid flag only with answer
   property p_valid_needs_wait;
      @(posedge ref_clk) disable iff (!reset_n)
      avmRsp.readdatavalid |-> !avmRsp.waitrequest;
   endproperty
   a_valid_needs_wait: assert property (p_valid_needs_wait) else $error("valid without answer");

   // state stays one-hot
   property p_state_onehot;
      @(posedge ref_clk) disable iff (!reset_n)
      $onehot(state_ff);
   endproperty
   a_state_onehot: assert property (p_state_onehot) else $error("state code illegal");

   // read data moves only on lookup
   property p_data_hold;
      @(posedge ref_clk) disable iff (!reset_n)
      (state_ff != ST_LOOK) |=> $stable(avmRsp.readdata);
   endproperty
   a_data_hold: assert property (p_data_hold) else $error("read data moved outside lookup");

   // lookup leads to answer
   property p_wait_after_look;
      @(posedge ref_clk) disable iff (!reset_n)
      (state_ff == ST_LOOK) |=> !avmRsp.waitrequest;
   endproperty
   a_wait_after_look: assert property (p_wait_after_look) else $error("lookup without answer");

   // taken request starts lookup
   property p_look_follows_req;
      @(posedge ref_clk) disable iff (!reset_n)
      takeReq |=> (state_ff == ST_LOOK);
   endproperty
   a_look_follows_req: assert property (p_look_follows_req) else $error("request not taken");

   // answer cycle returns to idle
   property p_done_to_idle;
      @(posedge ref_clk) disable iff (!reset_n)
      (state_ff == ST_DONE) |=> (state_ff == ST_IDLE);
   endproperty
   a_done_to_idle: assert property (p_done_to_idle) else $error("no return to idle");

   c_read: cover property (@(posedge ref_clk) disable iff (!reset_n) ack && avmReq.read);
   c_write: cover property (@(posedge ref_clk) disable iff (!reset_n) ack && avmReq.write);
   c_cont: cover property (@(posedge ref_clk) disable iff (!reset_n)
      ack && avmReq.read && ackIdx == `FQB_IDX_BURST_4);
   c_misaligned: cover property (@(posedge ref_clk) disable iff (!reset_n)
      ack && avmReq.read && !wordAligned);
endmodule
`default_nettype wire

// >>> rtl/fqb_table_rom.sv
`include "fqb_defs.svh"
`default_nettype none
module fqb_table_rom #(
   parameter logic [7:0] PART_COUNT = `FQB_VAL_PART_CNT_DEF
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // lookup
   input wire logic [`FQB_IW-1:0] index,
   output logic [7:0] data,
   output logic hit
);
   // entry lookup, unmapped and reserved read zero
   // fixed entry values
   function automatic logic [8:0] lookup(input logic [`FQB_IW-1:0] idx);
      unique case (idx)
         `FQB_IDX_PAGE_SIZE: lookup = {1'b1, `FQB_VAL_PAGE_SIZE};
         `FQB_IDX_BURST_CNT: lookup = {1'b1, `FQB_VAL_BURST_CNT};
         `FQB_IDX_BURST_1: lookup = {1'b1, `FQB_VAL_BURST_1};
         `FQB_IDX_BURST_2: lookup = {1'b1, `FQB_VAL_BURST_2};
         `FQB_IDX_BURST_3: lookup = {1'b1, `FQB_VAL_BURST_3};
         `FQB_IDX_BURST_4: lookup = {1'b1, `FQB_VAL_BURST_4};
         `FQB_IDX_PART_CNT: lookup = {1'b1, PART_COUNT};
         default: lookup = 9'h000;
      endcase
   endfunction
   wire logic [8:0] nxt_word = lookup(index);
   // registered read data
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         data <= 8'h00;
         hit <= 1'b0;
      end else begin
         data <= nxt_word[7:0];
         hit <= nxt_word[8];
      end
   end
endmodule
`default_nettype wire

// >>> tb/fqb_host_model.sv
`default_nettype none
module fqb_host_model (
   // clock
   input wire logic ref_clk,
   // avalon-mm master side
   output fqb_pkg::fqb_req_type avmReq,
   input wire fqb_pkg::fqb_rsp_type avmRsp
);
   import fqb_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   int timeoutHit = 0;
   // idle bus from time zero
   initial avmReq = '0;
   // one bus cycle, request held until waitrequest seen low
   task automatic access(input logic wr, input logic [9:0] addr, output logic [31:0] rd, output logic rv);
      int n;
      n = 0;
      avmReq <= '{read: !wr, write: wr, address: addr, writedata: 32'hFFFF_FFFF, byteenable: 4'hF};
      do begin
         @(posedge ref_clk);
         n++;
      end while (avmRsp.waitrequest !== 1'b0 && n < 50);
      rd = avmRsp.readdata;
      rv = avmRsp.readdatavalid;
      if (n >= 50) timeoutHit++;
      avmReq <= '0;
      @(posedge ref_clk); // one edge before the next request
   endtask
   // page reads only with a page buffer
   function automatic logic page_ok(input logic [7:0] code);
      return code != 8'h00;
   endfunction
   function automatic logic burst_ok(input logic [7:0] count);
      return count != 8'h00;
   endfunction
   function automatic logic [2:0] rcr_burst(input logic [7:0] code);
      return code[2:0];
   endfunction
endmodule
`default_nettype wire

// >>> tb/fqb_query_table_tb.sv
`default_nettype none
module fqb_query_table_tb;
   import fqb_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] PART_CNT = 8'h03;
   logic refClk;
   logic resetN;
   fqb_req_type avmReq;
   fqb_rsp_type avmRsp;
   int error_cnt = 0;
   int tests_run = 0;
   logic [7:0] expTab [7] = '{8'h03, 8'h04, 8'h01, 8'h02, 8'h03, 8'h07, PART_CNT};
   logic [31:0] rdData;
   logic rdValid;
   // block under test and host partner
   fqb_query_table #(.PART_COUNT(PART_CNT)) dut_u (.ref_clk(refClk), .reset_n(resetN),
      .avmReq(avmReq), .avmRsp(avmRsp));
   fqb_host_model host_u (.ref_clk(refClk), .avmReq(avmReq), .avmRsp(avmRsp));
   // 200 MHz clock
   initial begin
      refClk = 1'b0;
      forever #2.5 refClk = ~refClk;
   end
   // compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // bus cycle with hang guard
   task automatic bus(input logic wr, input logic [9:0] addr);
      host_u.access(wr, addr, rdData, rdValid);
      if (host_u.timeoutHit != 0) begin
         error_cnt++;
         final_report();
      end
      check({31'h0000_0000, rdValid}, {31'h0000_0000, !wr}); // valid flag on reads only
   endtask
   // response idle while in reset
   task automatic test_reset();
      check({31'h0000_0000, avmRsp.waitrequest}, 32'h0000_0001);
      check(avmRsp.readdata, 32'h0000_0000);
      $display("test_reset done");
   endtask
   // every entry read back to back
   task automatic test_table();
      for (int i = 0; i < 7; i++) begin
         bus(1'b0, 10'h130 + 10'(4 * i));
         check(rdData, {24'h00_0000, expTab[i]}); // table entry
         if (i == 0) check({31'h0000_0000, host_u.page_ok(rdData[7:0])}, 32'h0000_0001); // page reads
         if (i == 1) check({31'h0000_0000, host_u.burst_ok(rdData[7:0])}, 32'h0000_0001); // bursts
      end
      $display("test_table done");
   endtask
   // burst codes decode to 4, 8, 16 words and continuous
   task automatic test_burst();
      int words [3] = '{4, 8, 16};
      for (int i = 0; i < 4; i++) begin
         bus(1'b0, 10'h138 + 10'(4 * i));
         check({27'h000_0000, rdData[7:3]}, 32'h0000_0000); // reserved bits zero
         if (i < 3) begin
            check(32'h0000_0001 << (host_u.rcr_burst(rdData[7:0]) + 3'h1), 32'(words[i])); // burst length
         end else begin
            check({29'h0000_0000, rdData[2:0]}, 32'h0000_0007); // continuous code
         end
      end
      $display("test_burst done");
   endtask
   // writes leave entries unchanged
   task automatic test_write();
      for (int i = 0; i < 7; i++) begin
         bus(1'b1, 10'h130 + 10'(4 * i));
         bus(1'b0, 10'h130 + 10'(4 * i));
         check(rdData, {24'h00_0000, expTab[i]}); // entry kept after write
      end
      $display("test_write done");
   endtask
   // unmapped and misaligned addresses read zero
   task automatic test_unmapped();
      logic [9:0] addrs [4] = '{10'h12C, 10'h14C, 10'h131, 10'h3FC};
      for (int i = 0; i < 4; i++) begin
         bus(1'b0, addrs[i]);
         check(rdData, 32'h0000_0000); // outside table reads zero
      end
      $display("test_unmapped done");
   endtask
   // main sequence
   initial begin
      resetN = 1'b0;
      repeat (4) @(posedge refClk);
      test_reset();
      resetN <= 1'b1;
      @(posedge refClk);
      test_table();
      test_burst();
      test_write();
      test_unmapped();
      final_report();
   end
endmodule
`default_nettype wire
